// *** flash_status_cfg.svh ***
// timing, opcodes, field positions and reset values for the flash status block
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// =====================================================================
// opcodes
`define OPC_WRITE_STATUS1 8'h01
`define OPC_WRITE_STATUS2 8'h31
`define OPC_READ_STATUS 8'h05
`define OPC_READ_STATUS2 8'h35
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_RESET_ENABLE 8'hF0
`define OPC_RESET_CONFIRM 8'hD0

// =====================================================================
// field positions
`define SR1_LOCK_BIT 7
`define SR1_WPP_BIT 4
`define SR1_PROT_BIT 2
`define SR1_WEL_BIT 1
`define SR_BUSY_BIT 0
`define SR2_RESET_CMD_ENABLE_BIT 4

// =====================================================================
// reset values
`define LOCK_RESET 1'h0
`define PROT_RESET 1'h1
`define RESET_CMD_ENABLE_RESET 1'h0
`define WEL_RESET 1'h0

// =====================================================================
// timing
`define CORE_CLK_MHZ 100
`define SOFT_RESET_NS 100
`define SOFT_RESET_CYC ((`SOFT_RESET_NS * `CORE_CLK_MHZ + 999) / 1000)

`endif

// *** flash_status_pkg.sv ***
// types for the flash status register block
package flash_status_pkg;

  typedef enum logic [2:0] {
    CMD_IDLE = 3'b000,
    CMD_OPCODE = 3'b001,
    CMD_DATA = 3'b010,
    CMD_DISCARD = 3'b011,
    CMD_READ = 3'b100,
    CMD_IGNORE = 3'b101
  } cmd_state_t;

endpackage

// *** flash_status_props.sv ***
// concurrent checks on the flash status block ports
`timescale 1ns/10ps
module flash_status_props (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic WP_N,
  input wire logic PROTECT_LOCK,
  input wire logic ARRAY_PROTECT,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic RESET_CMD_ENABLE,
  input wire logic SOFT_RESET
);
  // =====================================================
  // properties
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // cycles the soft reset pulse has stood so far
  logic [3:0] soft_len_ff;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      soft_len_ff <= 4'h0;
    end else if (SOFT_RESET) begin
      soft_len_ff <= soft_len_ff + 4'h1;
    end else begin
      soft_len_ff <= 4'h0;
    end
  end
  lock_at_deselect_a:
    assert property ($changed(PROTECT_LOCK) |-> CS_N) else $error("lock moved while selected");
  prot_needs_wel_a:
    assert property ($changed(ARRAY_PROTECT) |-> $past(WRITE_ENABLE_LATCH))
    else $error("protect moved without write enable");
  prot_frozen_a:
    assert property ($changed(ARRAY_PROTECT) |-> !$past(PROTECT_LOCK) || $past(WP_N))
    else $error("protect moved while frozen");
  lock_clear_pin_a:
    assert property ($fell(PROTECT_LOCK) |-> $past(WP_N)) else $error("lock cleared with pin low");
  reset_cmd_enable_needs_wel_a:
    assert property ($changed(RESET_CMD_ENABLE) |-> $past(WRITE_ENABLE_LATCH))
    else $error("reset enable moved without write enable");
  reset_gated_a:
    assert property ($rose(SOFT_RESET) |-> RESET_CMD_ENABLE) else $error("reset taken while disabled");
  soft_width_a:
    assert property ($fell(SOFT_RESET) |-> soft_len_ff == 4'hA)
    else $error("soft reset width wrong");
  soft_long_a:
    assert property (SOFT_RESET |-> soft_len_ff != 4'hA)
    else $error("soft reset too long");
  reset_cmd_enable_kept_a:
    assert property (SOFT_RESET |-> $stable(RESET_CMD_ENABLE)) else $error("reset enable lost");
endmodule // flash_status_props
bind flash_status_register_control flash_status_props chk (
  .CORE_CLK(CORE_CLK),
  .RST(RST),
  .CS_N(CS_N),
  .WP_N(WP_N),
  .PROTECT_LOCK(PROTECT_LOCK),
  .ARRAY_PROTECT(ARRAY_PROTECT),
  .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
  .RESET_CMD_ENABLE(RESET_CMD_ENABLE),
  .SOFT_RESET(SOFT_RESET)
);

// *** flash_status_register_control.sv ***
// status register and write-status command logic of a serial flash
// Function
// [RL1] status read streams fresh status continuously
// [RL2] busy flag at bit 0, both bytes
// [RL3] reset enable clear at power-up blocks reset
// [RL4] reset enable set allows software reset
// [RL5] reset enable survives software reset
// [RL6] byte 2: bit4 enable, bit0 busy, rest zero
// [RL7] host sets write enable before status write
// [RL8] opcode 01h then data, bits 7 and 2
// [RL9] extra data bytes are discarded
// [RL10] on deselect update bits, clear write enable
// [RL11] protection change uses data, lock, pin
// [RL12] partial byte aborts, clears write enable
// [RL13] pin asserted: lock may only be set
// [RL14] host deasserts pin before clearing lock
// [RL15] write enable clear rejects writes
// [RL16] byte 1 only bits 7 and 2 writable
// [RL17] lock and pin freeze array protect
// [RL18] opcode 31h writes reset enable bit 4
`timescale 1ns/10ps
`include "flash_status_cfg.svh"
module flash_status_register_control (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic WP_N,
  input wire logic BUSY_IN,
  output logic SO,
  output logic SO_OE,
  output logic PROTECT_LOCK,
  output logic ARRAY_PROTECT,
  output logic WRITE_ENABLE_LATCH,
  output logic RESET_CMD_ENABLE,
  output logic SOFT_RESET
);

  // ===================================================================
  // state
  typedef struct packed {
    flash_status_pkg::cmd_state_t st_ff;
    logic [7:0] opcode_ff;
    logic [7:0] data_ff;
    logic [7:0] out_sh_ff;
    logic [2:0] out_cnt_ff;
    logic data_full_ff;
    logic lock_ff;
    logic prot_ff;
    logic wel_ff;
    logic reset_cmd_enable_ff;
    logic rst_armed_ff;
    logic [7:0] rst_cnt_ff;
    logic so_ff;
    logic so_oe_ff;
    logic soft_rst_ff;
  } ctl_state_t;

  localparam logic [7:0] RST_CYC = 8'(`SOFT_RESET_CYC);

  ctl_state_t cur_ff;
  ctl_state_t nxt_cur;

  logic sck_lvl, sck_rise, sck_fall;
  logic cs_lvl, cs_rise, cs_fall;
  logic si_lvl, wp_lvl, busy_lvl;
  logic [7:0] shifted;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic sh_clear;
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [7:0] status_live;

  // ===================================================================
  // pin synchronisers
  sync_edge u_sck (
    .clk(CORE_CLK),
    .rst(RST),
    .din(SCK),
    .level(sck_lvl),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  // select and protect pins idle high, so their flops reset high
  sync_edge #(.INIT(1'b1)) u_cs (
    .clk(CORE_CLK),
    .rst(RST),
    .din(CS_N),
    .level(cs_lvl),
    .rise(cs_rise),
    .fall(cs_fall)
  );

  sync_edge #(.INIT(1'b1)) u_wp (
    .clk(CORE_CLK),
    .rst(RST),
    .din(WP_N),
    .level(wp_lvl),
    .rise(),
    .fall()
  );

  // data and busy are read as levels only
  sync_edge u_si (
    .clk(CORE_CLK),
    .rst(RST),
    .din(SI),
    .level(si_lvl),
    .rise(),
    .fall()
  );

  sync_edge u_busy (
    .clk(CORE_CLK),
    .rst(RST),
    .din(BUSY_IN),
    .level(busy_lvl),
    .rise(),
    .fall()
  );

  // si and sck share synchroniser depth, so data stays aligned to the edge
  assign sh_clear = cs_fall | cs_lvl;

  spi_shift_in #(.WIDTH(8)) u_shift (
    .clk(CORE_CLK),
    .rst(RST),
    .clear(sh_clear),
    .sample(sck_rise & ~cs_lvl),
    .sdi(si_lvl),
    .shifted(shifted),
    .count(bit_cnt),
    .byte_done(byte_done)
  );

  // ===================================================================
  // status images
  always_comb begin
    sr1 = 8'h00;
    sr1[`SR1_LOCK_BIT] = cur_ff.lock_ff;
    sr1[`SR1_WPP_BIT] = wp_lvl;
    sr1[`SR1_PROT_BIT] = cur_ff.prot_ff;
    sr1[`SR1_WEL_BIT] = cur_ff.wel_ff;
    sr1[`SR_BUSY_BIT] = busy_lvl; // RL2
    sr2 = 8'h00; // RL6
    sr2[`SR2_RESET_CMD_ENABLE_BIT] = cur_ff.reset_cmd_enable_ff; // RL6
    sr2[`SR_BUSY_BIT] = busy_lvl; // RL2
    // a streamed read keeps returning the byte its opcode chose
    status_live = (cur_ff.opcode_ff == `OPC_READ_STATUS2) ? sr2 : sr1; // RL1
  end

  // ===================================================================
  // command engine
  always_comb begin
    logic wp_asserted;
    logic lock_new;
    logic prot_new;
    wp_asserted = 1'b0;
    lock_new = 1'b0;
    prot_new = 1'b0;
    nxt_cur = cur_ff;
    nxt_cur.soft_rst_ff = 1'b0;

    // =================================================================
    // soft reset timer
    if (cur_ff.rst_cnt_ff != 8'h00) begin
      nxt_cur.rst_cnt_ff = cur_ff.rst_cnt_ff - 8'h01;
      nxt_cur.soft_rst_ff = 1'b1;
    end

    if (cs_fall) begin
      nxt_cur.st_ff = flash_status_pkg::CMD_OPCODE;
      nxt_cur.data_full_ff = 1'b0;
    end

    // =================================================================
    // serial output
    if (sck_fall && cur_ff.so_oe_ff) begin
      nxt_cur.so_ff = cur_ff.out_sh_ff[7];
      nxt_cur.out_sh_ff = {cur_ff.out_sh_ff[6:0], 1'b0};
      nxt_cur.out_cnt_ff = cur_ff.out_cnt_ff + 3'h1;
      if (cur_ff.out_cnt_ff == 3'h7) begin
        // bit 0 leaves now; reload so polling sees a live busy flag
        nxt_cur.out_sh_ff = status_live; // RL1
      end
    end

    // =================================================================
    // opcode and data decode
    if (byte_done) begin
      unique case (cur_ff.st_ff)
        flash_status_pkg::CMD_OPCODE: begin
          nxt_cur.opcode_ff = shifted;
          nxt_cur.st_ff = flash_status_pkg::CMD_IGNORE;
          unique case (shifted)
            `OPC_WRITE_STATUS1, `OPC_WRITE_STATUS2: begin
              if (cur_ff.wel_ff) begin
                nxt_cur.st_ff = flash_status_pkg::CMD_DATA; // RL15 RL8 RL18
              end
            end
            `OPC_READ_STATUS: begin
              nxt_cur.st_ff = flash_status_pkg::CMD_READ;
              nxt_cur.out_sh_ff = sr1;
              nxt_cur.out_cnt_ff = 3'h0;
              nxt_cur.so_oe_ff = 1'b1;
            end
            `OPC_READ_STATUS2: begin
              nxt_cur.st_ff = flash_status_pkg::CMD_READ;
              nxt_cur.out_sh_ff = sr2; // RL6
              nxt_cur.out_cnt_ff = 3'h0;
              nxt_cur.so_oe_ff = 1'b1;
            end
            `OPC_WRITE_ENABLE: nxt_cur.wel_ff = 1'b1;
            `OPC_RESET_ENABLE: nxt_cur.rst_armed_ff = cur_ff.reset_cmd_enable_ff; // RL3
            `OPC_RESET_CONFIRM: begin
              if (cur_ff.reset_cmd_enable_ff && cur_ff.rst_armed_ff) begin
                // reset_cmd_enable_ff untouched here; survives the soft reset
                nxt_cur.rst_cnt_ff = RST_CYC; // RL4 RL5
                nxt_cur.wel_ff = 1'b0;
              end
            end
            default: nxt_cur.st_ff = flash_status_pkg::CMD_IGNORE;
          endcase
          // arming lasts one frame: any other opcode drops it
          if (shifted != `OPC_RESET_ENABLE) begin
            nxt_cur.rst_armed_ff = (shifted == `OPC_RESET_ENABLE);
          end
        end
        flash_status_pkg::CMD_DATA: begin
          nxt_cur.data_ff = shifted;
          nxt_cur.data_full_ff = 1'b1;
          nxt_cur.st_ff = flash_status_pkg::CMD_DISCARD; // RL9
        end
        flash_status_pkg::CMD_DISCARD: nxt_cur.st_ff = flash_status_pkg::CMD_DISCARD; // RL9
        default: nxt_cur.st_ff = cur_ff.st_ff;
      endcase
    end

    // =================================================================
    // completion on deselect
    if (cs_rise) begin
      nxt_cur.so_oe_ff = 1'b0;
      nxt_cur.so_ff = 1'b0;
      if (cur_ff.opcode_ff == `OPC_WRITE_DISABLE &&
          cur_ff.st_ff == flash_status_pkg::CMD_IGNORE && bit_cnt == 3'h0) begin
        nxt_cur.wel_ff = 1'b0;
      end
      if ((cur_ff.st_ff == flash_status_pkg::CMD_DATA) ||
          (cur_ff.st_ff == flash_status_pkg::CMD_DISCARD)) begin
        nxt_cur.wel_ff = 1'b0; // RL10 RL12
        if (cur_ff.data_full_ff && bit_cnt == 3'h0) begin // RL12
          wp_asserted = ~wp_lvl; // RL11
          if (cur_ff.opcode_ff == `OPC_WRITE_STATUS2) begin
            nxt_cur.reset_cmd_enable_ff = cur_ff.data_ff[`SR2_RESET_CMD_ENABLE_BIT]; // RL18 RL5
          end else begin
            lock_new = cur_ff.data_ff[`SR1_LOCK_BIT]; // RL8 RL16
            prot_new = cur_ff.data_ff[`SR1_PROT_BIT]; // RL8 RL16
            if (wp_asserted && cur_ff.lock_ff && !lock_new) begin
              // whole write dropped, only the latch clears
              nxt_cur.lock_ff = cur_ff.lock_ff; // RL13 RL14
            end else begin
              nxt_cur.lock_ff = lock_new; // RL10 RL13
              if (!(wp_asserted && cur_ff.lock_ff)) begin
                nxt_cur.prot_ff = prot_new; // RL11 RL17
              end
            end
          end
        end
      end
      nxt_cur.st_ff = flash_status_pkg::CMD_IDLE;
    end

    if (cur_ff.soft_rst_ff && cur_ff.rst_cnt_ff == 8'h00) begin
      nxt_cur.st_ff = flash_status_pkg::CMD_IDLE;
    end
  end

  // ===================================================================
  // registers
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cur_ff <= '0;
      cur_ff.lock_ff <= `LOCK_RESET;
      cur_ff.prot_ff <= `PROT_RESET;
      cur_ff.wel_ff <= `WEL_RESET;
      cur_ff.reset_cmd_enable_ff <= `RESET_CMD_ENABLE_RESET; // RL3
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ===================================================================
  // outputs, all straight from flops
  assign SO = cur_ff.so_ff;
  assign SO_OE = cur_ff.so_oe_ff;
  assign PROTECT_LOCK = cur_ff.lock_ff;
  assign ARRAY_PROTECT = cur_ff.prot_ff;
  assign WRITE_ENABLE_LATCH = cur_ff.wel_ff;
  assign RESET_CMD_ENABLE = cur_ff.reset_cmd_enable_ff;
  assign SOFT_RESET = cur_ff.soft_rst_ff;

endmodule // flash_status_register_control

// *** spi_host_model.sv ***
// serial host model driving mode 0 frames
`timescale 1ns/10ps
module spi_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // =====================================================
  // frame driver
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end
  // clock only runs inside a frame; data line toggles when unused
  task automatic xfer(input logic [23:0] bits, input int n, output logic [7:0] rd);
    int i;
    cs_n = 1'h0;
    #40;
    for (i = 0; i < n; i++) begin
      si = bits[23-i];
      #40;
      sck = 1'h1;
      rd = {rd[6:0], so};
      #40;
      sck = 1'h0;
    end
    si = ~si;
    #40;
    cs_n = 1'h1;
    #200;
  endtask
endmodule // spi_host_model

// *** spi_shift_in.sv ***
// serial input shifter counting bits within the current byte
`timescale 1ns/10ps
module spi_shift_in #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic sample,
  input wire logic sdi,
  output logic [WIDTH-1:0] shifted,
  output logic [$clog2(WIDTH)-1:0] count,
  output logic byte_done
);

  localparam int CW = $clog2(WIDTH);

  typedef struct packed {
    logic [WIDTH-1:0] sh_ff;
    logic [$clog2(WIDTH)-1:0] cnt_ff;
  } shift_state_t;

  shift_state_t cur_ff;
  shift_state_t nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    if (clear) begin
      nxt_cur = '0;
    end else if (sample) begin
      nxt_cur.sh_ff = {cur_ff.sh_ff[WIDTH-2:0], sdi};
      nxt_cur.cnt_ff = cur_ff.cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign shifted = {cur_ff.sh_ff[WIDTH-2:0], sdi};
  assign count = cur_ff.cnt_ff;
  assign byte_done = sample && (cur_ff.cnt_ff == CW'(WIDTH - 1));

endmodule // spi_shift_in

// *** sync_edge.sv ***
// two-flop synchroniser with rise and fall detection
`timescale 1ns/10ps
module sync_edge #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
  } sync_state_t;

  sync_state_t cur_ff;
  sync_state_t nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.s1_ff = din;
    nxt_cur.s2_ff = cur_ff.s1_ff;
    nxt_cur.s3_ff = cur_ff.s2_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // start at the pin's idle level so no false edge follows reset
      cur_ff <= {3{INIT}};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign level = cur_ff.s2_ff;
  assign rise = cur_ff.s2_ff & ~cur_ff.s3_ff;
  assign fall = ~cur_ff.s2_ff & cur_ff.s3_ff;

endmodule // sync_edge

// *** tb_flash_status_register_control.sv ***
// self-checking bench for the flash status block
`timescale 1ns/10ps
`define CMP(n, e, s) begin tests_run++; if ((e) !== (s)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module tb_flash_status_register_control;
  logic CORE_CLK = 1'h0;
  logic RST = 1'h1;
  logic WP_N = 1'h1;
  logic BUSY_IN = 1'h0;
  wire SCK, CS_N, SI, SO, SO_OE, PROTECT_LOCK, ARRAY_PROTECT;
  wire WRITE_ENABLE_LATCH, RESET_CMD_ENABLE, SOFT_RESET;
  int error_cnt = 0;
  int tests_run = 0;
  int resets = 0;
  logic [3:0] exp_q[$];
  logic [3:0] e;
  logic [7:0] rd;
  event chk;
  always #5 CORE_CLK = ~CORE_CLK;
  always @(posedge SOFT_RESET) resets++;
  flash_status_register_control dut (.*);
  spi_host_model host (.sck(SCK), .cs_n(CS_N), .si(SI), .so(SO));
  // =====================================================
  // helpers
  task close_out;
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // expected word is {lock, protect, write enable, reset enable}
  task cmd(input logic [7:0] op, input logic [7:0] d, input int n, input logic [3:0] x);
    @(negedge CORE_CLK);
    host.xfer({op, d, 8'hFF}, n, rd);
    exp_q.push_back(x);
    ->chk;
  endtask
  always @(chk) begin
    e = exp_q.pop_front();
    `CMP("bits", e, {PROTECT_LOCK, ARRAY_PROTECT, WRITE_ENABLE_LATCH, RESET_CMD_ENABLE})
  end
  // =====================================================
  // scenarios
  initial begin
    void'($urandom(32'h0E03));
    repeat (10) @(negedge CORE_CLK);
    RST = 1'h0;
    repeat (3) @(negedge CORE_CLK);
    BUSY_IN = 1'h1;
    cmd(8'h05, 8'h00, 16, 4'h4);
    `CMP("sr1 busy", 8'h15, rd)
    // busy drops mid-frame: the second streamed byte must show it
    fork
      cmd(8'h05, 8'h00, 24, 4'h4);
      #900 BUSY_IN = 1'h0;
    join
    `CMP("sr1 fresh", 8'h14, rd)
    BUSY_IN = 1'h0;
    cmd(8'h05, 8'h00, 16, 4'h4);
    `CMP("sr1 ready", 8'h14, rd)
    cmd(8'h01, 8'h84, 16, 4'h4);
    cmd(8'h06, 8'h00, 8, 4'h6);
    cmd(8'h01, 8'h80 | (8'($urandom) & 8'h7B), 16, 4'h8);
    WP_N = 1'h0;
    cmd(8'h06, 8'h00, 8, 4'hA);
    cmd(8'h01, 8'h00, 16, 4'h8);
    cmd(8'h06, 8'h00, 8, 4'hA);
    cmd(8'h01, 8'h84, 16, 4'h8);
    WP_N = 1'h1;
    cmd(8'h06, 8'h00, 8, 4'hA);
    cmd(8'h01, 8'h04, 12, 4'h8);
    cmd(8'h06, 8'h00, 8, 4'hA);
    cmd(8'h01, 8'h04, 24, 4'h4);
    cmd(8'hF0, 8'h00, 8, 4'h4);
    cmd(8'hD0, 8'h00, 8, 4'h4);
    `CMP("no reset", 0, resets)
    cmd(8'h06, 8'h00, 8, 4'h6);
    cmd(8'h31, 8'h10, 16, 4'h5);
    cmd(8'hF0, 8'h00, 8, 4'h5);
    cmd(8'hD0, 8'h00, 8, 4'h5);
    `CMP("one reset", 1, resets)
    BUSY_IN = 1'h1;
    cmd(8'h35, 8'h00, 16, 4'h5);
    `CMP("sr2 busy", 8'h11, rd)
    BUSY_IN = 1'h0;
    cmd(8'h06, 8'h00, 8, 4'h7);
    cmd(8'h31, 8'h00, 16, 4'h4);
    cmd(8'h06, 8'h00, 8, 4'h6);
    cmd(8'h31, 8'h10, 16, 4'h5);
    // power cycle in mid-run must drop reset enable
    RST = 1'h1;
    repeat (3) @(negedge CORE_CLK);
    RST = 1'h0;
    repeat (3) @(negedge CORE_CLK);
    `CMP("power up", 4'h4, {PROTECT_LOCK, ARRAY_PROTECT, WRITE_ENABLE_LATCH, RESET_CMD_ENABLE})
    cmd(8'h06, 8'h00, 8, 4'h6);
    cmd(8'h04, 8'h00, 8, 4'h4);
    cmd(8'h01, 8'h84, 16, 4'h4);
    close_out();
  end
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule // tb_flash_status_register_control
